// [design/dlm_pkg.sv]
package dlm_pkg;

  localparam int TW_W     = 48;
  localparam int CLAMP_W  = 24;
  localparam int ADDR_W   = 14;
  localparam int DATA_W   = 32;
  localparam int NREF     = 4;
  localparam int REF_W    = 2;
  localparam int AVG_LOG2 = 10;

  // Word indices; the byte address is four times the index.
  localparam logic [11:0] IDX_SYSCLK    = 12'h100;
  localparam logic [11:0] IDX_FREE_LO   = 12'h300;
  localparam logic [11:0] IDX_FREE_HI   = 12'h301;
  localparam logic [11:0] IDX_CLAMP_HI  = 12'h307;
  localparam logic [11:0] IDX_CLAMP_LO  = 12'h308;
  localparam logic [11:0] IDX_HIST_MODE = 12'h31B;
  localparam logic [11:0] IDX_PROF_BASE = 12'h600;
  localparam logic [11:0] IDX_LOOP_MODE = 12'hA01;
  localparam logic [11:0] IDX_STATUS    = 12'hD0A;
  localparam logic [11:0] IDX_TW_LO     = 12'hD10;
  localparam logic [11:0] IDX_TW_HI     = 12'hD11;

  localparam logic [TW_W-1:0]    FREE_TW_RST  = 48'h0000_0000_0000;
  localparam logic [CLAMP_W-1:0] CLAMP_HI_RST = 24'hFFFFFF;
  localparam logic [CLAMP_W-1:0] CLAMP_LO_RST = 24'h000000;
  localparam logic [7:0]         BYTE_RST     = 8'h00;
  localparam logic [31:0]        WORD_RST     = 32'h0000_0000;

  localparam logic [1:0] PATH_DIRECT    = 2'h0;
  localparam logic [1:0] PATH_LOW_SYNTH = 2'h1;
  localparam logic [1:0] PATH_CRYSTAL   = 2'h2;

  typedef enum {ST_FREERUN, ST_CLOSED, ST_SWITCH, ST_HOLD} dlm_state_t;

  typedef struct packed {
    logic [7:0]  pfd_ofs;
    logic [7:0]  divider;
    logic [15:0] coeff;
  } dlm_profile_t;

  typedef struct packed {
    logic [2:0] rsv;
    logic       doubler;
    logic [1:0] mdiv;
    logic [1:0] path;
  } dlm_sysclk_t;

  typedef struct packed {
    logic       rsv_hi;
    logic       user_hold;
    logic       user_freerun;
    logic       force_en;
    logic [1:0] rsv_lo;
    logic [1:0] force_ref;
  } dlm_loop_mode_t;

  typedef struct packed {
    logic [2:0] rsv;
    logic       fallback;
    logic       persist;
    logic [2:0] incr_k;
  } dlm_hist_mode_t;

  typedef struct packed {
    logic [22:0] rsv;
    logic        hist_valid;
    logic        freq_lock;
    logic        phase_lock;
    logic [1:0]  active_ref;
    logic [3:0]  state;
  } dlm_status_t;

endpackage

// [design/dlm_clamp.sv]
`timescale 1ns/1ps
module dlm_clamp
  import dlm_pkg::*;
#(
  parameter int W  = TW_W,
  parameter int CW = CLAMP_W
) (
  // Bounds and word
  input  wire logic [CW-1:0] upper_i,
  input  wire logic [CW-1:0] lower_i,
  input  wire logic [W-1:0]  tw_i,
  // Result
  output logic      [W-1:0]  tw_o
);

  localparam int PAD = W - CW;

  logic [W-1:0] upper_word;
  logic [W-1:0] lower_word;

  // The upper bound includes its whole granule so that the default
  // bounds leave every word untouched.
  assign upper_word = {upper_i, {PAD{1'b1}}};
  assign lower_word = {lower_i, {PAD{1'b0}}};

  always_comb begin
    if (tw_i > upper_word) begin
      tw_o = upper_word;
    end else if (tw_i < lower_word) begin
      tw_o = lower_word;
    end else begin
      tw_o = tw_i;
    end
  end

endmodule

// [design/dlm_history.sv]
`timescale 1ns/1ps
module dlm_history
  import dlm_pkg::*;
#(
  parameter int W    = TW_W,
  parameter int LOG2 = AVG_LOG2
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Control
  input  wire logic         clear_i,
  input  wire logic         sample_i,
  input  wire logic [W-1:0] tw_i,
  // Result
  output logic      [W-1:0] avg_o,
  output logic              valid_o
);

  logic [W+LOG2-1:0] acc_reg;
  logic [W+LOG2-1:0] acc_next;
  logic [LOG2-1:0]   cnt_reg;

  assign acc_next = acc_reg + (W+LOG2)'(tw_i);

  // Each interval is averaged on its own, with no memory of the last one.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_reg <= '0;
      cnt_reg <= '0;
    end else if (clear_i) begin
      acc_reg <= '0;
      cnt_reg <= '0;
    end else if (sample_i) begin
      cnt_reg <= cnt_reg + 1'b1;
      acc_reg <= (&cnt_reg) ? '0 : acc_next;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avg_o   <= '0;
      valid_o <= 1'b0;
    end else if (clear_i) begin
      valid_o <= 1'b0;
    end else if (sample_i && (&cnt_reg)) begin
      avg_o   <= acc_next[W+LOG2-1:LOG2];
      valid_o <= 1'b1;
    end
  end

endmodule

// [design/dlm_loop_ctrl.sv]
`timescale 1ns/1ps
module dlm_loop_ctrl
  import dlm_pkg::*;
#(
  parameter int N_REF    = NREF,
  parameter int HIST_LOG = AVG_LOG2
) (
  // Clock and reset
  input  wire logic                MCLK_I,
  input  wire logic                ARST_N_I,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0]   AVS_ADDRESS_I,
  input  wire logic                AVS_READ_I,
  input  wire logic                AVS_WRITE_I,
  input  wire logic [3:0]          AVS_BYTEENABLE_I,
  input  wire logic [DATA_W-1:0]   AVS_WRITEDATA_I,
  output logic      [DATA_W-1:0]   AVS_READDATA_O,
  output logic                     AVS_WAITREQUEST_O,
  // Loop inputs
  input  wire logic [N_REF-1:0]    REF_VALID_I,
  input  wire logic [TW_W-1:0]     FILTER_WORD_I,
  input  wire logic                PHASE_LOCK_I,
  input  wire logic                FREQ_LOCK_I,
  // Loop outputs
  output logic      [TW_W-1:0]     DDS_TUNING_WORD_O,
  output dlm_profile_t             PROFILE_O,
  output logic                     PROFILE_LOAD_O,
  output logic      [REF_W-1:0]    ACTIVE_REF_O,
  output logic                     LOOP_CLOSED_O,
  output logic                     HOLDOVER_O,
  output logic                     FREE_RUN_O,
  output logic                     PHASE_LOCK_O,
  output logic                     FREQ_LOCK_O,
  // System clock path control
  output logic      [1:0]          SYSCLK_PATH_O,
  output logic      [1:0]          SYSCLK_MDIV_O,
  output logic                     SYSCLK_DOUBLER_O
);

  dlm_state_t          state_reg;
  dlm_state_t          state_next;
  logic [REF_W-1:0]    active_ref_reg;
  logic [REF_W-1:0]    active_ref_next;
  logic [TW_W-1:0]     free_tw_reg;
  logic [CLAMP_W-1:0]  clamp_hi_reg;
  logic [CLAMP_W-1:0]  clamp_lo_reg;
  dlm_hist_mode_t      hist_mode_reg;
  dlm_loop_mode_t      loop_mode_reg;
  dlm_sysclk_t         sysclk_reg;
  dlm_profile_t        prof_reg [N_REF];
  logic [TW_W-1:0]     hold_tw_reg;
  logic                ack_reg;
  logic [11:0]         idx;
  logic                bus_req;
  logic                wr_take;
  logic [DATA_W-1:0]   rd_mux;
  logic [REF_W-1:0]    sel_ref;
  logic                sel_ok;
  logic                load;
  logic                enter_hold;
  logic                hist_clr;
  logic [TW_W-1:0]     tw_src;
  logic [TW_W-1:0]     tw_clamped;
  logic [TW_W-1:0]     hist_avg;
  logic                hist_valid;
  logic                lock_hold;
  dlm_status_t         status;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Lowest index wins among valid references unless software pins one.
  function automatic logic [REF_W-1:0] pick_ref(input logic [N_REF-1:0] v,
                                                input dlm_loop_mode_t m);
    logic [REF_W-1:0] r;
    r = m.force_ref;
    if (!m.force_en) begin
      for (int i = N_REF - 1; i >= 0; i--) begin
        if (v[i]) begin
          r = REF_W'(i);
        end
      end
    end
    return r;
  endfunction

  // Register bus: one wait cycle, then the answer.
  assign idx               = AVS_ADDRESS_I[ADDR_W-1:2];
  assign bus_req           = AVS_READ_I | AVS_WRITE_I;
  assign AVS_WAITREQUEST_O = bus_req & ~ack_reg;
  assign wr_take           = AVS_WRITE_I & ack_reg;

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req & ~ack_reg;
    end
  end

  assign status = '{rsv: '0, hist_valid: hist_valid,
                    freq_lock: FREQ_LOCK_O, phase_lock: PHASE_LOCK_O,
                    active_ref: active_ref_reg, state: 4'(state_reg)};

  always_comb begin
    rd_mux = WORD_RST;
    case (idx)
      IDX_SYSCLK:    rd_mux = 32'(sysclk_reg);
      IDX_FREE_LO:   rd_mux = free_tw_reg[31:0];
      IDX_FREE_HI:   rd_mux = 32'(free_tw_reg[TW_W-1:32]);
      IDX_CLAMP_HI:  rd_mux = 32'(clamp_hi_reg);
      IDX_CLAMP_LO:  rd_mux = 32'(clamp_lo_reg);
      IDX_HIST_MODE: rd_mux = 32'(hist_mode_reg);
      IDX_LOOP_MODE: rd_mux = 32'(loop_mode_reg);
      IDX_STATUS:    rd_mux = status;
      IDX_TW_LO:     rd_mux = DDS_TUNING_WORD_O[31:0];
      IDX_TW_HI:     rd_mux = 32'(DDS_TUNING_WORD_O[TW_W-1:32]);
      default: begin
        for (int i = 0; i < N_REF; i++) begin
          if (idx == IDX_PROF_BASE + 12'(i)) begin
            rd_mux = prof_reg[i];
          end
        end
      end
    endcase
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      AVS_READDATA_O <= WORD_RST;
    end else if (AVS_READ_I && !ack_reg) begin
      AVS_READDATA_O <= rd_mux;
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      free_tw_reg   <= FREE_TW_RST;
      clamp_hi_reg  <= CLAMP_HI_RST;
      clamp_lo_reg  <= CLAMP_LO_RST;
      hist_mode_reg <= BYTE_RST;
      loop_mode_reg <= BYTE_RST;
      sysclk_reg    <= BYTE_RST;
      for (int i = 0; i < N_REF; i++) begin
        prof_reg[i] <= WORD_RST;
      end
    end else if (wr_take) begin
      case (idx)
        IDX_SYSCLK:
          sysclk_reg <= 8'(merge(32'(sysclk_reg), AVS_WRITEDATA_I,
                                 AVS_BYTEENABLE_I));
        IDX_FREE_LO:
          free_tw_reg[31:0] <= merge(free_tw_reg[31:0], AVS_WRITEDATA_I,
                                     AVS_BYTEENABLE_I);
        IDX_FREE_HI:
          free_tw_reg[TW_W-1:32] <= 16'(merge(32'(free_tw_reg[TW_W-1:32]),
                                              AVS_WRITEDATA_I,
                                              AVS_BYTEENABLE_I));
        IDX_CLAMP_HI:
          clamp_hi_reg <= 24'(merge(32'(clamp_hi_reg), AVS_WRITEDATA_I,
                                    AVS_BYTEENABLE_I));
        IDX_CLAMP_LO:
          clamp_lo_reg <= 24'(merge(32'(clamp_lo_reg), AVS_WRITEDATA_I,
                                    AVS_BYTEENABLE_I));
        IDX_HIST_MODE:
          hist_mode_reg <= 8'(merge(32'(hist_mode_reg), AVS_WRITEDATA_I,
                                    AVS_BYTEENABLE_I));
        IDX_LOOP_MODE:
          loop_mode_reg <= 8'(merge(32'(loop_mode_reg), AVS_WRITEDATA_I,
                                    AVS_BYTEENABLE_I));
        default: begin
          for (int i = 0; i < N_REF; i++) begin
            if (idx == IDX_PROF_BASE + 12'(i)) begin
              prof_reg[i] <= merge(prof_reg[i], AVS_WRITEDATA_I,
                                   AVS_BYTEENABLE_I);
            end
          end
        end
      endcase
    end
  end

  assign sel_ref = pick_ref(REF_VALID_I, loop_mode_reg);
  assign sel_ok  = REF_VALID_I[sel_ref];

  // Forced modes take priority over every automatic decision except the ST_SWITCH
  // step, which finishes first; free-run first, then user holdover.
  always_comb begin
    state_next      = state_reg;
    active_ref_next = active_ref_reg;
    load            = 1'b0;
    enter_hold      = 1'b0;
    hist_clr        = 1'b0;
    case (state_reg)
      ST_FREERUN: begin
        if (loop_mode_reg.user_freerun) begin
          state_next = ST_FREERUN;
        end else if (loop_mode_reg.user_hold) begin
          state_next = ST_HOLD;
          enter_hold = 1'b1;
        end else if (sel_ok) begin
          state_next      = ST_CLOSED;
          active_ref_next = sel_ref;
          load            = 1'b1;
          hist_clr        = (sel_ref != active_ref_reg) &
                            ~hist_mode_reg.persist;
        end
      end
      ST_CLOSED: begin
        if (loop_mode_reg.user_freerun) begin
          state_next = ST_FREERUN;
        end else if (loop_mode_reg.user_hold) begin
          state_next = ST_HOLD;
          enter_hold = 1'b1;
        end else if (sel_ok && sel_ref != active_ref_reg) begin
          state_next = ST_SWITCH;
          enter_hold = 1'b1;
        end else if (!REF_VALID_I[active_ref_reg]) begin
          state_next = ST_HOLD;
          enter_hold = 1'b1;
        end
      end
      ST_SWITCH: begin
        if (sel_ok) begin
          state_next      = ST_CLOSED;
          active_ref_next = sel_ref;
          load            = 1'b1;
          hist_clr        = ~hist_mode_reg.persist;
        end else begin
          state_next = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (loop_mode_reg.user_freerun) begin
          state_next = ST_FREERUN;
        end else if (!loop_mode_reg.user_hold && sel_ok) begin
          state_next      = ST_CLOSED;
          active_ref_next = sel_ref;
          load            = 1'b1;
          hist_clr        = (sel_ref != active_ref_reg) &
                            ~hist_mode_reg.persist;
        end
      end
      default: begin
        state_next = ST_FREERUN;
      end
    endcase
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state_reg      <= ST_FREERUN;
      active_ref_reg <= '0;
    end else begin
      state_reg      <= state_next;
      active_ref_reg <= active_ref_next;
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      PROFILE_O      <= WORD_RST;
      PROFILE_LOAD_O <= 1'b0;
    end else begin
      PROFILE_LOAD_O <= load;
      if (load) begin
        PROFILE_O <= prof_reg[active_ref_next];
      end
    end
  end

  dlm_history #(
    .W    (TW_W),
    .LOG2 (HIST_LOG)
  ) u_history (
    .clk_i    (MCLK_I),
    .rst_n_i  (ARST_N_I),
    .clear_i  (hist_clr),
    .sample_i (state_reg == ST_CLOSED),
    .tw_i     (FILTER_WORD_I),
    .avg_o    (hist_avg),
    .valid_o  (hist_valid)
  );

  // The held word is frozen at entry so the loop filter no longer steers it.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      hold_tw_reg <= FREE_TW_RST;
    end else if (enter_hold) begin
      if (hist_valid) begin
        hold_tw_reg <= hist_avg;
      end else if (hist_mode_reg.fallback) begin
        hold_tw_reg <= DDS_TUNING_WORD_O;
      end else begin
        hold_tw_reg <= free_tw_reg;
      end
    end
  end

  always_comb begin
    case (state_reg)
      ST_CLOSED:  tw_src = FILTER_WORD_I;
      ST_FREERUN: tw_src = free_tw_reg;
      default:    tw_src = hold_tw_reg;
    endcase
  end

  dlm_clamp #(
    .W  (TW_W),
    .CW (CLAMP_W)
  ) u_clamp (
    .upper_i (clamp_hi_reg),
    .lower_i (clamp_lo_reg),
    .tw_i    (tw_src),
    .tw_o    (tw_clamped)
  );

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      DDS_TUNING_WORD_O <= FREE_TW_RST;
    end else begin
      DDS_TUNING_WORD_O <= tw_clamped;
    end
  end

  // Lock outputs freeze across the short switchover holdover so that
  // software never sees a phantom unlock.
  assign lock_hold = (state_reg == ST_SWITCH) | (state_next == ST_SWITCH);

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      PHASE_LOCK_O <= 1'b0;
      FREQ_LOCK_O  <= 1'b0;
    end else if (lock_hold) begin
      PHASE_LOCK_O <= PHASE_LOCK_O;
      FREQ_LOCK_O  <= FREQ_LOCK_O;
    end else begin
      PHASE_LOCK_O <= (state_reg == ST_CLOSED) & PHASE_LOCK_I;
      FREQ_LOCK_O  <= (state_reg == ST_CLOSED) & FREQ_LOCK_I;
    end
  end

  assign ACTIVE_REF_O  = active_ref_reg;
  assign LOOP_CLOSED_O = (state_reg == ST_CLOSED);
  assign HOLDOVER_O    = (state_reg == ST_HOLD) | (state_reg == ST_SWITCH);
  assign FREE_RUN_O    = (state_reg == ST_FREERUN);

  // The doubler bit passes through as written; keeping its input under
  // the limit is left to the configuring software.
  assign SYSCLK_PATH_O    = sysclk_reg.path;
  assign SYSCLK_MDIV_O    = sysclk_reg.mdiv;
  assign SYSCLK_DOUBLER_O = sysclk_reg.doubler;

endmodule

// [sim/dlm_ref_model.sv]
`timescale 1ns/1ps
module dlm_ref_model
  import dlm_pkg::*;
(
  // Clock and reset
  input  wire logic            clk_i,
  input  wire logic            rst_n_i,
  // Bench controls
  input  wire logic [NREF-1:0] valid_i,
  input  wire logic [TW_W-1:0] word_i,
  input  wire logic            lock_i,
  // Monitor and loop filter side
  output logic      [NREF-1:0] ref_valid_o,
  output logic      [TW_W-1:0] filt_word_o,
  output logic                 phase_lock_o,
  output logic                 freq_lock_o
);
  // Lock claims fall with the references, as a real detector's would.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ref_valid_o  <= '0;
      filt_word_o  <= '0;
      phase_lock_o <= 1'b0;
      freq_lock_o  <= 1'b0;
    end else begin
      ref_valid_o  <= valid_i;
      filt_word_o  <= word_i;
      phase_lock_o <= lock_i & (|valid_i);
      freq_lock_o  <= lock_i & (|valid_i);
    end
  end
endmodule

// [sim/dlm_loop_ctrl_props.sv]
`timescale 1ns/1ps
module dlm_loop_ctrl_props
  import dlm_pkg::*;
(
  // Clock and reset
  input wire logic              MCLK_I,
  input wire logic              ARST_N_I,
  // Register bus
  input wire logic [ADDR_W-1:0] AVS_ADDRESS_I,
  input wire logic              AVS_READ_I,
  input wire logic              AVS_WRITE_I,
  input wire logic [3:0]        AVS_BYTEENABLE_I,
  input wire logic [DATA_W-1:0] AVS_WRITEDATA_I,
  input wire logic              AVS_WAITREQUEST_O,
  // Loop outputs
  input wire logic [TW_W-1:0]   DDS_TUNING_WORD_O,
  input wire logic              PROFILE_LOAD_O,
  input wire logic              LOOP_CLOSED_O,
  input wire logic              HOLDOVER_O,
  input wire logic              FREE_RUN_O,
  input wire logic              PHASE_LOCK_O,
  input wire logic              FREQ_LOCK_O,
  input wire logic [1:0]        SYSCLK_PATH_O,
  input wire logic [1:0]        SYSCLK_MDIV_O,
  input wire logic              SYSCLK_DOUBLER_O
);
  logic wr_done;
  logic hold_reg;
  logic frun_reg;

  // Mirror of the forcing bits, updated on the same edge as the register.
  assign wr_done = AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_BYTEENABLE_I[0];
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      hold_reg <= 1'b0;
      frun_reg <= 1'b0;
    end else if (wr_done && AVS_ADDRESS_I[13:2] == IDX_LOOP_MODE) begin
      hold_reg <= AVS_WRITEDATA_I[6];
      frun_reg <= AVS_WRITEDATA_I[5];
    end
  end

  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!ARST_N_I);

  property p_mode_onehot; $onehot({LOOP_CLOSED_O, HOLDOVER_O, FREE_RUN_O});
  endproperty
  a_mode_onehot: assert property (p_mode_onehot)
    else $error("loop mode outputs not one-hot");
  property p_hold_const; HOLDOVER_O && $past(HOLDOVER_O) &&
    $past(HOLDOVER_O, 2) |-> $stable(DDS_TUNING_WORD_O); endproperty
  a_hold_const: assert property (p_hold_const)
    else $error("tuning word moved in holdover");
  property p_close_load; $rose(LOOP_CLOSED_O) |-> PROFILE_LOAD_O; endproperty
  a_close_load: assert property (p_close_load)
    else $error("loop closed without profile load");
  property p_switch_lock; LOOP_CLOSED_O ##1 HOLDOVER_O ##1 LOOP_CLOSED_O |->
    $past({PHASE_LOCK_O, FREQ_LOCK_O}) ==
    $past({PHASE_LOCK_O, FREQ_LOCK_O}, 2); endproperty
  a_switch_lock: assert property (p_switch_lock)
    else $error("lock outputs moved during switchover");
  property p_bus_wait; (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=>
    !AVS_WAITREQUEST_O; endproperty
  a_bus_wait: assert property (p_bus_wait)
    else $error("bus answer not after one wait cycle");
  property p_sysclk; wr_done && AVS_ADDRESS_I[13:2] == IDX_SYSCLK |=>
    {SYSCLK_DOUBLER_O, SYSCLK_MDIV_O, SYSCLK_PATH_O} ==
    $past(AVS_WRITEDATA_I[4:0]); endproperty
  a_sysclk: assert property (p_sysclk)
    else $error("clock path outputs differ from write");
  property p_force_free; $rose(frun_reg) |-> ##[0:2] FREE_RUN_O; endproperty
  a_force_free: assert property (p_force_free)
    else $error("forced free-run not entered");
  property p_force_hold; $rose(hold_reg) && !frun_reg |-> ##[0:2] HOLDOVER_O;
  endproperty
  a_force_hold: assert property (p_force_hold)
    else $error("forced holdover not entered");
  property p_hold_keep; hold_reg && !frun_reg && HOLDOVER_O &&
    $past(HOLDOVER_O) |=> HOLDOVER_O; endproperty
  a_hold_keep: assert property (p_hold_keep)
    else $error("holdover left while user hold set");
endmodule

bind dlm_loop_ctrl dlm_loop_ctrl_props dlm_loop_ctrl_props_i (
  .MCLK_I(MCLK_I), .ARST_N_I(ARST_N_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
  .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
  .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
  .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
  .DDS_TUNING_WORD_O(DDS_TUNING_WORD_O), .PROFILE_LOAD_O(PROFILE_LOAD_O),
  .LOOP_CLOSED_O(LOOP_CLOSED_O), .HOLDOVER_O(HOLDOVER_O),
  .FREE_RUN_O(FREE_RUN_O), .PHASE_LOCK_O(PHASE_LOCK_O),
  .FREQ_LOCK_O(FREQ_LOCK_O), .SYSCLK_PATH_O(SYSCLK_PATH_O),
  .SYSCLK_MDIV_O(SYSCLK_MDIV_O), .SYSCLK_DOUBLER_O(SYSCLK_DOUBLER_O));

// [sim/tb_top.sv]
`timescale 1ns/1ps
module tb_top import dlm_pkg::*;;
  logic              clk = 1'b0;
  logic              arst_n = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic              rd = 1'b0;
  logic              wr = 1'b0;
  logic [3:0]        be = 4'h0;
  logic [DATA_W-1:0] wdata = '0;
  logic [NREF-1:0]   valid_set = '0;
  logic [TW_W-1:0]   word_set = '0;
  logic              lock_set = 1'b1;
  logic [31:0]       lfsr = 32'h2358;
  int                fails = 0;
  int                n_tests = 0;
  logic [DATA_W-1:0] rdata, q;
  logic [NREF-1:0]   ref_valid;
  logic [TW_W-1:0]   filt_word, w, w2, fw;
  logic              waitreq, plock, flock, closed, hold, frun, sdbl;
  dlm_profile_t      prof;
  logic [REF_W-1:0]  act;
  logic [1:0]        spath, smdiv;
  logic [4:0]        sc;
  logic [3:0]        msk;
  logic [31:0]       pv [4];

  always #20 clk = ~clk;

  dlm_ref_model dlm_ref_model_i (.clk_i(clk), .rst_n_i(arst_n),
    .valid_i(valid_set), .word_i(word_set), .lock_i(lock_set),
    .ref_valid_o(ref_valid), .filt_word_o(filt_word), .phase_lock_o(plock),
    .freq_lock_o(flock));
  // A short history average keeps the holdover cases quick.
  dlm_loop_ctrl #(.N_REF(NREF), .HIST_LOG(4)) dlm_loop_ctrl_i (
    .MCLK_I(clk), .ARST_N_I(arst_n), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_BYTEENABLE_I(be), .AVS_WRITEDATA_I(wdata),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
    .REF_VALID_I(ref_valid), .FILTER_WORD_I(filt_word),
    .PHASE_LOCK_I(plock), .FREQ_LOCK_I(flock), .DDS_TUNING_WORD_O(),
    .PROFILE_O(prof), .PROFILE_LOAD_O(), .ACTIVE_REF_O(act),
    .LOOP_CLOSED_O(closed), .HOLDOVER_O(hold), .FREE_RUN_O(frun),
    .PHASE_LOCK_O(), .FREQ_LOCK_O(), .SYSCLK_PATH_O(spath),
    .SYSCLK_MDIV_O(smdiv), .SYSCLK_DOUBLER_O(sdbl));

  function automatic logic [31:0] nxt(input logic [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [47:0] clampw(input logic [47:0] v,
                                         input logic [23:0] up);
    clampw = (v[47:24] > up) ? {up, 24'hFFFFFF} : v;
  endfunction
  function automatic logic [1:0] lowest(input logic [3:0] m);
    lowest = 2'h0;
    for (int k = 3; k >= 0; k--) if (m[k]) lowest = 2'(k);
  endfunction
  task automatic end_of_test;
    if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rnd48(output logic [47:0] v);
    lfsr = nxt(lfsr);
    v[47:16] = lfsr;
    lfsr = nxt(lfsr);
    v[15:0] = lfsr[15:0];
  endtask
  // The request stays up until waitrequest is sampled low at a rising edge;
  // read data is taken at that same edge and only then is the request dropped.
  task automatic bus(input logic we, input logic [11:0] idx,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= {idx, 2'b00};
    wr <= we;
    rd <= !we;
    wdata <= d;
    be <= 4'hF;
    @(posedge clk);
    while (waitreq !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n == 20) chk(1'b0, 1'b1);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rd_tw(output logic [47:0] v);
    bus(1'b0, IDX_TW_HI, 32'h0);
    v[47:32] = q[15:0];
    bus(1'b0, IDX_TW_LO, 32'h0);
    v[31:0] = q;
  endtask
  task automatic mode(input logic [2:0] m);
    int n;
    n = 0;
    while ({closed, hold, frun} !== m && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk({closed, hold, frun}, m);
  endtask
  task automatic set_refs(input logic [3:0] m, input logic [47:0] v);
    @(posedge clk);
    valid_set <= m;
    word_set <= v;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    end_of_test;
  end

  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      sc = {i % 3 == 1, 2'(i), 2'(i % 3)};
      bus(1'b1, IDX_SYSCLK, {27'h0, sc});
      @(negedge clk);
      chk({sdbl, smdiv, spath}, sc);
    end
    bus(1'b1, 12'h0FF, 32'hFFFF_FFFF);
    bus(1'b0, 12'h0FF, 32'h0);
    chk(q, 48'h0);
    rnd48(fw);
    bus(1'b1, IDX_FREE_LO, fw[31:0]);
    bus(1'b1, IDX_FREE_HI, {16'h0, fw[47:32]});
    mode(3'b001);
    rd_tw(w);
    chk(w, fw);
    bus(1'b1, IDX_CLAMP_HI, {8'h0, fw[47:24] - 24'h1});
    rd_tw(w);
    chk(w, clampw(fw, fw[47:24] - 24'h1));
    bus(1'b1, IDX_CLAMP_HI, 32'h00FF_FFFF);
    rnd48(w2);
    set_refs(4'h1, w2);
    mode(3'b100);
    bus(1'b0, IDX_STATUS, 32'h0);
    chk(q[8], 1'b0);
    set_refs(4'h0, w2);
    mode(3'b010);
    rd_tw(w);
    chk(w, fw);
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    bus(1'b1, IDX_HIST_MODE, 32'h10);
    rnd48(w2);
    set_refs(4'h1, w2);
    mode(3'b100);
    set_refs(4'h0, w2);
    mode(3'b010);
    rd_tw(w);
    chk(w, w2);
    bus(1'b1, IDX_HIST_MODE, 32'h0);
    rnd48(w2);
    set_refs(4'h1, w2);
    mode(3'b100);
    repeat (40) @(posedge clk);
    bus(1'b0, IDX_STATUS, 32'h0);
    chk(q[8], 1'b1);
    set_refs(4'h0, w2);
    mode(3'b010);
    rd_tw(w);
    chk(w, w2);
    for (int k = 0; k < 4; k++) begin
      lfsr = nxt(lfsr);
      pv[k] = lfsr;
      bus(1'b1, IDX_PROF_BASE + 12'(k), lfsr);
    end
    set_refs(4'h3, w2);
    mode(3'b100);
    repeat (40) @(posedge clk);
    set_refs(4'h2, w2);
    repeat (6) @(negedge clk);
    chk(act, 2'h1);
    chk(prof, pv[1]);
    bus(1'b0, IDX_STATUS, 32'h0);
    chk(q[8], 1'b0);
    chk(q[7:6], 2'b11);
    bus(1'b1, IDX_LOOP_MODE, 32'h12);
    set_refs(4'h7, w2);
    repeat (6) @(negedge clk);
    chk(act, 2'h2);
    bus(1'b1, IDX_LOOP_MODE, 32'h40);
    mode(3'b010);
    repeat (20) @(posedge clk);
    chk(hold, 1'b1);
    bus(1'b1, IDX_LOOP_MODE, 32'h60);
    mode(3'b001);
    bus(1'b1, IDX_LOOP_MODE, 32'h0);
    mode(3'b100);
    chk(prof, pv[0]);
    for (int j = 0; j < 6; j++) begin
      lfsr = nxt(lfsr);
      msk = (lfsr[3:0] == 4'h0) ? 4'h4 : lfsr[3:0];
      // Lock claims change with the references so a thawed lock would show.
      @(posedge clk);
      lock_set <= lfsr[4];
      valid_set <= msk;
      repeat (6) @(negedge clk);
      chk(act, lowest(msk));
      chk(prof, pv[lowest(msk)]);
    end
    bus(1'b1, IDX_HIST_MODE, 32'h08);
    set_refs(4'h1, w2);
    repeat (40) @(posedge clk);
    set_refs(4'h8, w2);
    repeat (6) @(negedge clk);
    bus(1'b0, IDX_STATUS, 32'h0);
    chk(q[8], 1'b1);
    end_of_test;
  end
endmodule
